// >>> include/nvt_pkg.sv
// Constants of the timekeeping RAM: memory map, masks, offsets, timing.
// Assumes one 250 MHz system clock.
package nvt_pkg;
    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int SYS_CLK_HZ = 250_000_000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int SEC_CYCLES = SYS_CLK_HZ;
    localparam int TEST_HZ = 512;
    localparam int TEST_HALF_CYCLES = SYS_CLK_HZ / (2 * TEST_HZ);
    localparam int RST_HOLD_NS = 1000;
    localparam logic [15:0] RST_HOLD_CYCLES =
        16'((RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // ------------------------------------------------------------------
    // Byte-wide memory map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam logic [11:0] CLK_BLOCK = 12'hfff;
    localparam logic [2:0] IDX_CENT = 3'h0;
    localparam logic [2:0] IDX_SEC = 3'h1;
    localparam logic [2:0] IDX_MIN = 3'h2;
    localparam logic [2:0] IDX_HOUR = 3'h3;
    localparam logic [2:0] IDX_DAY = 3'h4;
    localparam logic [2:0] IDX_DATE = 3'h5;
    localparam logic [2:0] IDX_MON = 3'h6;
    localparam logic [2:0] IDX_YEAR = 3'h7;
    localparam logic [7:0] FIELD_MASK [0:7] = '{8'h3f, 8'h7f, 8'h7f,
        8'h3f, 8'h07, 8'h3f, 8'h1f, 8'hff};
    localparam int BIT_WRITE = 7;
    localparam int BIT_READ = 6;
    localparam int BIT_HALT = 7;
    localparam int BIT_CELL = 7;
    localparam int BIT_FREQ = 6;
    // ------------------------------------------------------------------
    // Housekeeping registers on APB
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_MASK = 12'h004;
    localparam logic [11:0] OFS_STATE = 12'h008;
    localparam int EV_TICK = 0;
    localparam int EV_SUPPLY_FAIL = 1;
    localparam int EV_IGNORED = 2;
    localparam int EV_LOADED = 3;
    localparam int EV_W = 4;
    localparam logic [3:0] MASK_RESET = 4'h0;
endpackage

// >>> verilog/nvt_byte_ram.sv
// Byte-wide RAM array, one synchronous port.
// Assumes the caller gates writes; read data one edge later.
`timescale 1ns/1ps
module nvt_byte_ram (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_we,
    input wire logic [14:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:32767];

    // Storage write
    always_ff @(posedge i_sys_clk) begin
        if (i_clk_en && i_we) begin
            mem[i_addr] <= i_wdata;
        end
    end

    // Registered read
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_clk_en) begin
            o_rdata <= mem[i_addr];
        end
    end
endmodule

// >>> verilog/nvt_calendar.sv
// BCD counters, seconds to century, with month lengths and leap days.
// Assumes one i_tick pulse per second and a load strobe.
`timescale 1ns/1ps
module nvt_calendar (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_tick,
    input wire logic i_load,
    input wire logic [7:0] i_ld_sec,
    input wire logic [7:0] i_ld_min,
    input wire logic [7:0] i_ld_hour,
    input wire logic [7:0] i_ld_day,
    input wire logic [7:0] i_ld_date,
    input wire logic [7:0] i_ld_mon,
    input wire logic [7:0] i_ld_year,
    input wire logic [7:0] i_ld_cent,
    output logic [7:0] o_sec,
    output logic [7:0] o_min,
    output logic [7:0] o_hour,
    output logic [7:0] o_day,
    output logic [7:0] o_date,
    output logic [7:0] o_mon,
    output logic [7:0] o_year,
    output logic [7:0] o_cent
);
    // Packed BCD increment by one
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {4'(v[7:4] + 4'h1), 4'h0}
            : {v[7:4], 4'(v[3:0] + 4'h1)};
    endfunction

    logic leap;
    logic [7:0] month_end;
    logic c_min, c_hour, c_day, c_mon, c_year, c_cent;

    // Year divisible by four, read straight from the two BCD digits
    assign leap = v_leap(o_year);
    function automatic logic v_leap(input logic [7:0] y);
        v_leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                      : (y[3:0] == 4'h0 || y[3:0] == 4'h4 ||
                         y[3:0] == 4'h8);
    endfunction

    // Last date of the current month
    always_comb begin
        case (o_mon)
            8'h02: month_end = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
            default: month_end = 8'h31;
        endcase
    end

    // Carry chain from seconds up to century
    assign c_min = i_tick && o_sec == 8'h59;
    assign c_hour = c_min && o_min == 8'h59;
    assign c_day = c_hour && o_hour == 8'h23;
    assign c_mon = c_day && o_date == month_end;
    assign c_year = c_mon && o_mon == 8'h12;
    assign c_cent = c_year && o_year == 8'h99;

    // Counter update, load has priority over counting
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sec <= 8'h00;
            o_min <= 8'h00;
            o_hour <= 8'h00;
            o_day <= 8'h01;
            o_date <= 8'h01;
            o_mon <= 8'h01;
            o_year <= 8'h00;
            o_cent <= 8'h20;
        end else if (i_clk_en && i_load) begin
            o_sec <= i_ld_sec;
            o_min <= i_ld_min;
            o_hour <= i_ld_hour;
            o_day <= i_ld_day;
            o_date <= i_ld_date;
            o_mon <= i_ld_mon;
            o_year <= i_ld_year;
            o_cent <= i_ld_cent;
        end else if (i_clk_en && i_tick) begin
            o_sec <= c_min ? 8'h00 : bcd_inc(o_sec);
            if (c_min) o_min <= c_hour ? 8'h00 : bcd_inc(o_min);
            if (c_hour) o_hour <= c_day ? 8'h00 : bcd_inc(o_hour);
            if (c_day) o_day <= (o_day == 8'h07) ? 8'h01 : bcd_inc(o_day);
            if (c_day) o_date <= c_mon ? 8'h01 : bcd_inc(o_date);
            if (c_mon) o_mon <= c_year ? 8'h01 : bcd_inc(o_mon);
            if (c_year) o_year <= c_cent ? 8'h00 : bcd_inc(o_year);
            if (c_cent) o_cent <= (o_cent == 8'h39) ? 8'h00 : bcd_inc(o_cent);
        end
    end
endmodule

// >>> verilog/nvt_timekeeper.sv
// Timekeeping RAM top: byte port, clock bytes, power fail, APB, irq.
// Assumes pins synchronous to i_sys_clk; DQ resolved from o_dq_oe.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps

module nvt_timekeeper #(
    parameter int TICK_CYCLES = nvt_pkg::SEC_CYCLES,
    parameter int TEST_HALF = nvt_pkg::TEST_HALF_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic [14:0] i_addr,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq,
    output logic o_dq_oe,
    input wire logic i_supply_ok,
    input wire logic i_cell_ok,
    output logic o_rst_n_out,
    output logic o_rst_n_oe,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_irq
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic sel, wr, clk_hit, ram_we;
    logic [2:0] idx;
    logic [7:0] ram_rdata;
    logic [7:0] vis [0:7];
    logic [7:0] cnt [0:7];
    logic [7:0] clk_byte, rd_clk;
    logic hit_d;
    logic w_bit, r_bit, halt, freq_test, w_prev;
    logic freeze, load;
    logic [31:0] pre_cnt;
    logic tick;
    logic [31:0] test_cnt;
    logic test_tog;
    logic supply_prev;
    logic [15:0] rst_cnt;
    logic [nvt_pkg::EV_W-1:0] status, mask, ev_set, ev_clr, next_status;
    logic apb_setup, apb_write;
    logic [31:0] next_prdata;
    logic map_hit;

    // ------------------------------------------------------------------
    // Byte-wide port decode
    // ------------------------------------------------------------------
    // Accesses count only while the supply is in tolerance
    assign sel = i_supply_ok && !i_ce_n;
    assign wr = sel && !i_we_n;
    assign o_dq_oe = sel && !i_oe_n && i_we_n;
    assign idx = i_addr[2:0];
    assign clk_hit = i_addr[14:3] == nvt_pkg::CLK_BLOCK;
    assign ram_we = wr && !clk_hit;

    // RAM below the clock block
    nvt_byte_ram u_ram (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_we(ram_we),
        .i_addr(i_addr),
        .i_wdata(i_dq),
        .o_rdata(ram_rdata)
    );

    // ------------------------------------------------------------------
    // Control bits held in the clock bytes
    // ------------------------------------------------------------------
    // Write and read bits in century, stop bit in seconds, test bit in day
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            w_bit <= 1'b0;
            r_bit <= 1'b0;
            halt <= 1'b0;
            freq_test <= 1'b0;
            w_prev <= 1'b0;
        end else if (i_clk_en) begin
            w_prev <= w_bit;
            if (wr && clk_hit && idx == nvt_pkg::IDX_CENT) begin
                w_bit <= i_dq[nvt_pkg::BIT_WRITE];
                r_bit <= i_dq[nvt_pkg::BIT_READ];
            end
            if (wr && clk_hit && idx == nvt_pkg::IDX_SEC) begin
                halt <= i_dq[nvt_pkg::BIT_HALT];
            end
            if (wr && clk_hit && idx == nvt_pkg::IDX_DAY) begin
                freq_test <= i_dq[nvt_pkg::BIT_FREQ];
            end
        end
    end

    // Visible copy frozen by either bit; counters loaded as write bit drops
    assign freeze = w_bit || r_bit;
    assign load = w_prev && !w_bit;

    // ------------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------------
    // One-second prescaler, stopped while the oscillator is halted
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pre_cnt <= 32'h00000000;
        end else if (i_clk_en) begin
            if (halt || load || pre_cnt == 32'(TICK_CYCLES - 1)) begin
                pre_cnt <= 32'h00000000;
            end else begin
                pre_cnt <= pre_cnt + 32'h00000001;
            end
        end
    end
    assign tick = !halt && !load && pre_cnt == 32'(TICK_CYCLES - 1);

    // Square wave for the frequency test bit
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            test_cnt <= 32'h00000000;
            test_tog <= 1'b0;
        end else if (i_clk_en && !halt) begin
            test_tog <= test_tog ^ (test_cnt == 32'(TEST_HALF - 1));
            test_cnt <= (test_cnt == 32'(TEST_HALF - 1)) ? 32'h00000000
                : test_cnt + 32'h00000001;
        end
    end

    // ------------------------------------------------------------------
    // Calendar counters
    // ------------------------------------------------------------------
    // Running counters; load takes the visible copy written by the host
    nvt_calendar u_cal (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_tick(tick),
        .i_load(load),
        .i_ld_sec(vis[nvt_pkg::IDX_SEC]),
        .i_ld_min(vis[nvt_pkg::IDX_MIN]),
        .i_ld_hour(vis[nvt_pkg::IDX_HOUR]),
        .i_ld_day(vis[nvt_pkg::IDX_DAY]),
        .i_ld_date(vis[nvt_pkg::IDX_DATE]),
        .i_ld_mon(vis[nvt_pkg::IDX_MON]),
        .i_ld_year(vis[nvt_pkg::IDX_YEAR]),
        .i_ld_cent(vis[nvt_pkg::IDX_CENT]),
        .o_sec(cnt[nvt_pkg::IDX_SEC]),
        .o_min(cnt[nvt_pkg::IDX_MIN]),
        .o_hour(cnt[nvt_pkg::IDX_HOUR]),
        .o_day(cnt[nvt_pkg::IDX_DAY]),
        .o_date(cnt[nvt_pkg::IDX_DATE]),
        .o_mon(cnt[nvt_pkg::IDX_MON]),
        .o_year(cnt[nvt_pkg::IDX_YEAR]),
        .o_cent(cnt[nvt_pkg::IDX_CENT])
    );

    // ------------------------------------------------------------------
    // Visible copy of the clock bytes
    // ------------------------------------------------------------------
    // Each byte follows its counter in one cycle unless frozen or written
    for (genvar gi = 0; gi < 8; gi++) begin : g_vis
        always_ff @(posedge i_sys_clk or posedge i_rst) begin
            if (i_rst) begin
                vis[gi] <= 8'h00;
            end else if (i_clk_en) begin
                if (wr && clk_hit && idx == 3'(gi)) begin
                    vis[gi] <= i_dq & nvt_pkg::FIELD_MASK[gi];
                end else if (!freeze) begin
                    vis[gi] <= cnt[gi];
                end
            end
        end
    end

    // Clock byte with control bits and cell flag merged in
    always_comb begin
        clk_byte = vis[idx];
        case (idx)
            nvt_pkg::IDX_CENT: begin
                clk_byte[nvt_pkg::BIT_WRITE] = w_bit;
                clk_byte[nvt_pkg::BIT_READ] = r_bit;
            end
            nvt_pkg::IDX_SEC: begin
                clk_byte[nvt_pkg::BIT_HALT] = halt;
                clk_byte[0] = vis[idx][0] ^ (freq_test && test_tog);
            end
            nvt_pkg::IDX_DAY: begin
                clk_byte[nvt_pkg::BIT_CELL] = i_cell_ok;
                clk_byte[nvt_pkg::BIT_FREQ] = freq_test;
            end
            default: ;
        endcase
    end

    // ------------------------------------------------------------------
    // Read data pipeline
    // ------------------------------------------------------------------
    // Two stages so RAM and clock bytes leave from the same flop
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_clk <= 8'h00;
            hit_d <= 1'b0;
            o_dq <= 8'h00;
        end else if (i_clk_en) begin
            rd_clk <= clk_byte;
            hit_d <= clk_hit;
            o_dq <= hit_d ? rd_clk : ram_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Power fail and reset output
    // ------------------------------------------------------------------
    // Reset pin held low from reset and after supply loss, then released
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rst_cnt <= nvt_pkg::RST_HOLD_CYCLES;
            supply_prev <= 1'b0;
        end else if (i_clk_en) begin
            supply_prev <= i_supply_ok;
            if (!i_supply_ok) begin
                rst_cnt <= nvt_pkg::RST_HOLD_CYCLES;
            end else if (rst_cnt != 16'h0000) begin
                rst_cnt <= rst_cnt - 16'h0001;
            end
        end
    end
    assign o_rst_n_out = 1'b0;
    assign o_rst_n_oe = !i_supply_ok || rst_cnt != 16'h0000;

    // ------------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------------
    // Sticky events, set wins over a same-cycle clear
    assign ev_set[nvt_pkg::EV_TICK] = tick;
    assign ev_set[nvt_pkg::EV_SUPPLY_FAIL] = supply_prev && !i_supply_ok;
    assign ev_set[nvt_pkg::EV_IGNORED] = !i_supply_ok && !i_ce_n;
    assign ev_set[nvt_pkg::EV_LOADED] = load;
    assign ev_clr = apb_write && i_paddr == nvt_pkg::OFS_STATUS ?
        i_pwdata[nvt_pkg::EV_W-1:0] : 4'h0;
    assign next_status = (status & ~ev_clr) | ev_set;
    assign o_irq = |(status & mask);

    // Status and mask registers
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            status <= 4'h0;
            mask <= nvt_pkg::MASK_RESET;
        end else if (i_clk_en) begin
            status <= next_status;
            if (apb_write && i_paddr == nvt_pkg::OFS_MASK) begin
                mask <= i_pwdata[nvt_pkg::EV_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // Zero-wait slave; read data captured in the setup cycle
    assign apb_setup = i_psel && !i_penable;
    assign apb_write = i_psel && i_penable && i_pwrite;
    assign map_hit = i_paddr == nvt_pkg::OFS_STATUS ||
        i_paddr == nvt_pkg::OFS_MASK || i_paddr == nvt_pkg::OFS_STATE;
    assign o_pready = 1'b1;
    always_comb begin
        case (i_paddr)
            nvt_pkg::OFS_STATUS: next_prdata = {28'h0000000, status};
            nvt_pkg::OFS_MASK: next_prdata = {28'h0000000, mask};
            nvt_pkg::OFS_STATE: next_prdata = {27'h0000000, i_cell_ok,
                i_supply_ok, halt, r_bit, w_bit};
            default: next_prdata = 32'h00000000;
        endcase
    end

    // Registered read data and error flag
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else if (i_clk_en && apb_setup) begin
            o_prdata <= i_pwrite ? 32'h00000000 : next_prdata;
            o_pslverr <= !map_hit;
        end
    end
endmodule

// >>> verif/nvt_timekeeper_properties.sv
// Checker on the timekeeping RAM top ports.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ps
module nvt_props (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic [14:0] i_addr,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_supply_ok,
    input wire logic [7:0] o_dq,
    input wire logic o_dq_oe,
    input wire logic o_rst_n_out,
    input wire logic o_rst_n_oe,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_irq
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic mask_set;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // Remembers that software has written the mask
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst)
            mask_set <= 1'b0;
        else if (i_clk_en && i_psel && i_penable && i_pwrite
                 && i_paddr == 12'h004)
            mask_set <= 1'b1;
    end
    // RAM byte read held with a steady address
    sequence steady_read;
        (!i_ce_n && !i_oe_n && i_we_n && i_supply_ok && i_clk_en
            && i_addr < 15'h7ff8 && $stable(i_addr)) [*3];
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    dq_drive_a: assert property (o_dq_oe == (i_supply_ok &&
        !i_ce_n && !i_oe_n && i_we_n)) else $error("drive enable wrong");
    read_hold_a: assert property (steady_read |-> $stable(o_dq))
        else $error("read data moved");
    pull_low_a: assert property (!i_supply_ok |-> o_rst_n_oe)
        else $error("reset pin not pulled on supply loss");
    low_only_a: assert property (o_rst_n_out == 1'b0)
        else $error("reset pin driven high");
    rst_hold_a: assert property ($past(i_rst) |-> o_rst_n_oe [*8])
        else $error("reset pin released early");
    apb_ready_a: assert property (i_psel && i_penable |-> o_pready)
        else $error("no ready in access");
    bad_addr_a: assert property (i_psel && !i_penable && i_clk_en
        && i_paddr > 12'h008 |=> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped access not refused");
    good_addr_a: assert property (i_psel && !i_penable && i_clk_en
        && i_paddr == 12'h000 |=> !o_pslverr)
        else $error("mapped access refused");
    irq_quiet_a: assert property (!mask_set |-> !o_irq)
        else $error("interrupt while all masked");
    freeze_hold_a: assert property (!i_clk_en |=> $stable(o_dq)
        && $stable(o_prdata)) else $error("outputs moved while frozen");
endmodule

bind nvt_timekeeper nvt_props nvt_props_inst (.i_sys_clk, .i_rst,
    .i_clk_en, .i_addr, .i_ce_n, .i_oe_n, .i_we_n, .i_supply_ok, .o_dq,
    .o_dq_oe, .o_rst_n_out, .o_rst_n_oe, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .o_prdata, .o_pready, .o_pslverr, .o_irq);

// >>> verif/nvt_host_model.sv
// Host processor model on the byte-wide memory bus.
// Assumes the bench resolves the data wire into i_bus.
`timescale 1ns/1ps
module nvt_host_model (
    input wire logic i_sys_clk,
    input wire logic [7:0] i_bus,
    output logic [14:0] o_addr,
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic [7:0] o_dq
);
    // Idle bus: deselected
    initial begin
        o_addr = 15'h0000;
        o_ce_n = 1'b1;
        o_oe_n = 1'b1;
        o_we_n = 1'b1;
        o_dq = 8'h5a;
    end
    // Write cycle with strobes low for one edge
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        o_addr <= a;
        o_dq <= d;
        o_ce_n <= 1'b0;
        o_we_n <= 1'b0;
        @(posedge i_sys_clk);
        o_ce_n <= 1'b1;
        o_we_n <= 1'b1;
        o_dq <= ~d; // Released data stops showing the last value
    endtask
    // Read cycle held until the data has settled
    task automatic rd(input logic [14:0] a, output logic [7:0] d);
        @(posedge i_sys_clk);
        o_addr <= a;
        o_ce_n <= 1'b0;
        o_oe_n <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        d = i_bus;
        o_ce_n <= 1'b1;
        o_oe_n <= 1'b1;
    endtask
endmodule

// >>> verif/tb_nv_sram_timekeeper.sv
// Self-checking bench for the timekeeping RAM.
// Assumes a shortened one-second count of 20 cycles.
`timescale 1ns/1ps
module tb_nv_sram_timekeeper;
    logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, supply_ok = 1'b1;
    logic cell_ok = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q, lfsr;
    logic pready, pslverr, irq, ce_n, oe_n, we_n, dq_oe, r_out, r_oe;
    logic [14:0] addr, a;
    logic [7:0] h_dq, d_dq, got;
    wire logic [7:0] bus = dq_oe ? d_dq : h_dq;
    int errors, compares, cyc, tm [8];
    int cases [5][8] = '{'{20,59,59,23,7,28,2,1}, '{20,59,59,23,1,28,2,4},
        '{20,59,59,23,3,31,12,99}, '{20,9,30,10,2,15,6,7},
        '{20,5,0,0,1,1,1,0}};
    logic [7:0] mem [int];

    nvt_timekeeper #(.TICK_CYCLES(20), .TEST_HALF(3)) nvt_timekeeper_inst (
        .i_sys_clk(clk), .i_rst(rst), .i_clk_en(clk_en), .i_addr(addr),
        .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_dq(h_dq),
        .o_dq(d_dq), .o_dq_oe(dq_oe), .i_supply_ok(supply_ok),
        .i_cell_ok(cell_ok), .o_rst_n_out(r_out), .o_rst_n_oe(r_oe),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq));
    nvt_host_model nvt_host_model_inst (.i_sys_clk(clk), .i_bus(bus),
        .o_addr(addr), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
        .o_dq(h_dq));

    // ----------------------------------------
    // Clock, timeout, model and helpers
    // ----------------------------------------
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            print_verdict();
        end
    end
    function automatic logic [7:0] b2(input int x);
        return 8'((x / 10) * 16 + x % 10);
    endfunction
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Advance the reference calendar by one second
    task automatic tick1();
        int dim;
        dim = (tm[6] == 4 || tm[6] == 6 || tm[6] == 9 || tm[6] == 11) ? 30
            : (tm[6] != 2) ? 31 : (tm[7] % 4 == 0) ? 29 : 28;
        tm[1] = (tm[1] + 1) % 60;
        if (tm[1] == 0)
            tm[2] = (tm[2] + 1) % 60;
        if (tm[1] + tm[2] == 0)
            tm[3] = (tm[3] + 1) % 24;
        if (tm[1] + tm[2] + tm[3] == 0) begin
            tm[4] = tm[4] % 7 + 1;
            tm[5] = tm[5] % dim + 1;
            if (tm[5] == 1)
                tm[6] = tm[6] % 12 + 1;
            if (tm[5] == 1 && tm[6] == 1)
                tm[7] = (tm[7] + 1) % 100;
            if (tm[5] + tm[6] + tm[7] == 2)
                tm[0] = (tm[0] + 1) % 40;
        end
    endtask
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        cmp32(32'(g), 32'(e));
    endtask
    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // APB transfer; read data lands in q
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Load a time, let it run (halted in case 4), freeze and read it back
    task automatic clock_case(input int k);
        tm = cases[k];
        a = 15'h7ff8;
        nvt_host_model_inst.wr(a, 8'h80 | b2(tm[0]));
        for (int i = 1; i < 8; i++)
            nvt_host_model_inst.wr(a + 15'(i),
                b2(tm[i]) | (i == 1 && k == 4 ? 8'h80 : 8'h00));
        nvt_host_model_inst.wr(a, b2(tm[0]));
        repeat (30) @(posedge clk);
        if (k != 4)
            tick1();
        nvt_host_model_inst.wr(a, 8'h40 | b2(tm[0]));
        for (int i = 0; i < 8; i++) begin
            nvt_host_model_inst.rd(a + 15'(i), got);
            cmp8(got & nvt_pkg::FIELD_MASK[i], b2(tm[i]));
        end
        nvt_host_model_inst.wr(a, b2(tm[0]));
    endtask
    task automatic print_verdict();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        lfsr = 32'hd977;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            lfsr = nxt(lfsr);
            a = (i < 2) ? (i ? 15'h7ff7 : 15'h0) : lfsr[14:0] & 15'h7ff7;
            mem[a] = lfsr[23:16];
            nvt_host_model_inst.wr(a, lfsr[23:16]);
        end
        foreach (mem[k]) begin
            nvt_host_model_inst.rd(15'(k), got);
            cmp8(got, mem[k]);
        end
        clk_en <= 1'b0;
        repeat (3) @(posedge clk);
        clk_en <= 1'b1;
        for (int k = 0; k < 5; k++)
            clock_case(k);
        for (int c = 0; c < 2; c++) begin
            cell_ok <= c[0];
            repeat (2) @(posedge clk);
            apb(1'b0, nvt_pkg::OFS_STATE, 32'h0);
            cmp32(q & 32'h1f, 32'h0c | 32'(c << 4));
        end
        apb(1'b0, nvt_pkg::OFS_MASK, 32'h0);
        cmp32(q, 32'(nvt_pkg::MASK_RESET));
        apb(1'b1, nvt_pkg::OFS_MASK, 32'h6);
        apb(1'b1, nvt_pkg::OFS_STATUS, 32'hf);
        @(negedge clk);
        cmp32(32'(irq), 32'h0);
        @(posedge clk);
        supply_ok <= 1'b0;
        nvt_host_model_inst.wr(15'h0, ~mem[0]);
        @(negedge clk);
        cmp32(32'(irq), 32'h1);
        cmp32(32'({r_out, r_oe}), 32'h1);
        @(posedge clk);
        supply_ok <= 1'b1;
        apb(1'b1, nvt_pkg::OFS_MASK, 32'h0);
        @(negedge clk);
        cmp32(32'(irq), 32'h0);
        apb(1'b0, nvt_pkg::OFS_STATUS, 32'h0);
        cmp32(q & 32'h6, 32'h6);
        apb(1'b1, nvt_pkg::OFS_STATUS, 32'h6);
        apb(1'b1, nvt_pkg::OFS_MASK, 32'h6);
        @(negedge clk);
        cmp32(32'(irq), 32'h0);
        nvt_host_model_inst.rd(15'h0, got);
        cmp8(got, mem[0]);
        apb(1'b0, 12'h00c, 32'h0);
        cmp32({q[30:0], pslverr}, 32'h1);
        print_verdict();
    end
endmodule
